// ===== verilog/wake_up_control.v
// Wake-up control, wake filter enables and wake status with a Wishbone slave.
`timescale 1ns/100ps
`default_nettype none

`include "wake_map.vh"

// Functional notes
// - Control bit 0 enables magic-packet wake; resets to zero.
// - The wake enable of bit 0 loads from configuration word 1Ah.
// - Control bit 1 mirrors the bus power management enable, read-write.
// - Control bit 2 sets on any wakeup event; equals bus wake status.
// - Writing one to control bit 2 clears both status copies.
// - With bit 3 set, an enabled magic packet sets status, wakes host.
// - Control bit 4 enables wake on link change; resets to zero.
// - With bit 5 set, link wake follows control bits, not filter bit 0.
// - Control bit 8 flags PHY wake support, loaded from word 13h bit 8.
// - Control bits 6, 7 and 9 to 31 are read-only zeros.
// - With auxiliary power, status clears only by power-good or software.
// - Without auxiliary power, bus reset release also clears status.
// - Each filter enable bit switches its wake filter; all reset to zero.
// - Filter bits 0 to 7 enable the predefined wake filters in order.
// - With filter bit 15 set, manageability packets raise no wake event.
// - Filter bits 16-23 enable flex filters; 8-14 and 24-31 read zero.
// - A matching packet sets its status bits; writing one clears them.
module wake_up_control (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave.
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [15:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Non-volatile configuration load.
    input  wire        nvm_load_i,
    input  wire [15:0] nvm_apm_word_i,
    input  wire [15:0] nvm_phy_word_i,
    // Receive side match results, same clock.
    input  wire        packet_done_i,
    input  wire [7:0]  predefined_match_i,
    input  wire [7:0]  flex_match_i,
    input  wire        manageability_pass_i,
    input  wire        link_change_i,
    // Configuration-space power management access, same clock.
    input  wire        cfg_pme_enable_write_i,
    input  wire        cfg_pme_enable_i,
    input  wire        cfg_pme_status_clear_i,
    // Platform pins, asynchronous.
    input  wire        auxiliary_power_present_i,
    input  wire        power_good_i,
    input  wire        pci_reset_n_i,
    // Wake outputs.
    output reg         pme_status_o,
    output reg         pme_enable_o,
    output reg         host_wake_o
);

    wire [2:0]  pins_sync;
    wire        aux_present;
    wire        power_good;
    wire        pci_reset_n;
    reg         pci_reset_n_prev;
    wire        pci_reset_release;

    reg         apm_wake_enable;
    reg         assert_wake_on_magic;
    reg         link_change_wake_enable;
    reg         link_change_wake_override;
    reg         phy_wake_capable;
    reg         magic_wake_pending;
    reg  [31:0] wake_filter_enables;
    reg  [31:0] wake_status;

    wire        bus_req;
    wire        bus_write;
    wire        ctl_write;
    wire        flt_write;
    wire        sts_write;
    wire [31:0] byte_mask;
    wire [31:0] ctl_image;
    reg  [31:0] next_dat;

    wire        link_wake_allowed;
    wire        link_event;
    wire        packet_allowed;
    wire [31:0] match_vector;
    wire [31:0] status_set;
    wire        filter_event;
    wire        magic_event;
    wire        wake_event;
    wire        status_clear_hw;
    wire        status_clear_sw;
    reg  [31:0] next_status;
    reg         next_pme_status;

    pin_sync #(
        .WIDTH     (3),
        .RESET_VAL (1'b1)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({auxiliary_power_present_i, power_good_i, pci_reset_n_i}),
        .sync_o  (pins_sync)
    );

    assign aux_present = pins_sync[2];
    assign power_good  = pins_sync[1];
    assign pci_reset_n = pins_sync[0];

    // Release of the bus reset is a rising edge of the synchronised level.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pci_reset_n_prev <= 1'b1;
        end else begin
            pci_reset_n_prev <= pci_reset_n;
        end
    end

    assign pci_reset_release = pci_reset_n & ~pci_reset_n_prev;

    // Bus decode; a write takes effect at the edge where ack is high.
    assign bus_req   = cyc_i & stb_i;
    assign bus_write = bus_req & we_i & ack_o;
    assign ctl_write = bus_write & (adr_i == `WAKE_CONTROL_ADDR);
    assign flt_write = bus_write & (adr_i == `WAKE_FILTER_ENABLES_ADDR);
    assign sts_write = bus_write & (adr_i == `WAKE_STATUS_ADDR);
    assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                        {8{sel_i[1]}}, {8{sel_i[0]}}};

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req & ~ack_o;
        end
    end

    // Control register image; unlisted bits are constant zero.
    assign ctl_image = {23'h0,
                        phy_wake_capable,
                        2'b00,
                        link_change_wake_override,
                        link_change_wake_enable,
                        assert_wake_on_magic,
                        pme_status_o,
                        pme_enable_o,
                        apm_wake_enable};

    always @* begin
        next_dat = 32'h0000_0000;
        case (adr_i)
            `WAKE_CONTROL_ADDR: begin
                next_dat = ctl_image & (`WAKE_CONTROL_RW_MASK | 32'h0000_0004);
            end
            `WAKE_FILTER_ENABLES_ADDR: begin
                next_dat = wake_filter_enables &
                           `WAKE_FILTER_RW_MASK;
            end
            `WAKE_STATUS_ADDR: begin
                next_dat = wake_status & `WAKE_STATUS_MASK;
            end
            default: begin
                next_dat = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req & ~we_i & ~ack_o) begin
            dat_o <= next_dat;
        end
    end

    // Control bits written by software or loaded from configuration.
    always @(posedge clk_i) begin
        if (rst_i) begin
            apm_wake_enable           <= 1'b0;
            assert_wake_on_magic      <= 1'b1;
            link_change_wake_enable   <= 1'b0;
            link_change_wake_override <= 1'b0;
            phy_wake_capable          <= 1'b0;
        end else if (nvm_load_i) begin
            apm_wake_enable <=
                nvm_apm_word_i[`NVM_APM_WORD_APM_WAKE_ENABLE_BIT];
            phy_wake_capable <=
                nvm_phy_word_i[`NVM_PHY_WORD_WAKE_BIT];
        end else if (ctl_write) begin
            if (sel_i[0]) begin
                apm_wake_enable <=
                    dat_i[`APM_WAKE_ENABLE_BIT];
                assert_wake_on_magic      <= dat_i[`ASSERT_WAKE_ON_MAGIC_BIT];
                link_change_wake_enable <=
                    dat_i[`LINK_CHANGE_WAKE_EN_BIT];
                link_change_wake_override <= dat_i[`LINK_CHANGE_OVERRIDE_BIT];
            end
            if (sel_i[1]) begin
                phy_wake_capable <= dat_i[`PHY_WAKE_CAPABLE_BIT];
            end
        end
    end

    // Power management enable is shared by software and configuration space.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pme_enable_o <= 1'b0;
        end else if (ctl_write & sel_i[0]) begin
            pme_enable_o <= dat_i[`PME_ENABLE_BIT];
        end else if (cfg_pme_enable_write_i) begin
            pme_enable_o <= cfg_pme_enable_i;
        end
    end

    // Filter enables; reserved bits never store a value.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_filter_enables <= `WAKE_FILTER_RESET;
        end else if (flt_write) begin
            wake_filter_enables <= (wake_filter_enables & ~byte_mask) |
                                   (dat_i & byte_mask &
                                    `WAKE_FILTER_RW_MASK);
        end
    end

    // Link-change wake source selection.
    assign link_wake_allowed = link_change_wake_override ?
        (apm_wake_enable & link_change_wake_enable) :
        wake_filter_enables[`LINK_CHANGE_FILTER_BIT];
    assign link_event = link_change_i & link_wake_allowed;

    // Manageability traffic may be excluded from waking.
    assign packet_allowed = packet_done_i &
        ~(wake_filter_enables[`IGNORE_MNG_BIT] &
          manageability_pass_i);

    assign match_vector = {8'h00, flex_match_i, 8'h00,
                           predefined_match_i[7:1], 1'b0};
    assign status_set =
        ({32{packet_allowed}} & match_vector &
         wake_filter_enables & `WAKE_STATUS_MASK) |
        {31'h0, link_event};
    assign filter_event = |status_set;
    assign magic_event  = packet_allowed & apm_wake_enable &
        assert_wake_on_magic &
        predefined_match_i[`MAGIC_PACKET_FILTER_BIT];
    assign wake_event   = filter_event | magic_event;

    // Hardware clears: power loss always, bus reset release on main power.
    assign status_clear_hw = ~power_good |
                             (~aux_present & pci_reset_release);
    assign status_clear_sw = (ctl_write & sel_i[0] &
                              dat_i[`PME_STATUS_BIT]) |
                             cfg_pme_status_clear_i;

    // Setting has priority over every clear in the same cycle.
    always @* begin
        next_status = wake_status;
        if (status_clear_hw) begin
            next_status = 32'h0000_0000;
        end
        if (sts_write) begin
            next_status = next_status & ~(dat_i & byte_mask);
        end
        next_status = (next_status | status_set) & `WAKE_STATUS_MASK;
    end

    always @* begin
        next_pme_status = pme_status_o;
        if (status_clear_hw | status_clear_sw) begin
            next_pme_status = 1'b0;
        end
        if (wake_event) begin
            next_pme_status = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_status  <= 32'h0000_0000;
            pme_status_o <= 1'b0;
        end else begin
            wake_status  <= next_status;
            pme_status_o <= next_pme_status;
        end
    end

    // A magic wake under the control bit wakes the host regardless of enable.
    always @(posedge clk_i) begin
        if (rst_i) begin
            magic_wake_pending <= 1'b0;
        end else if (magic_event) begin
            magic_wake_pending <= 1'b1;
        end else if (~next_pme_status) begin
            magic_wake_pending <= 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            host_wake_o <= 1'b0;
        end else begin
            host_wake_o <= next_pme_status &
                           (pme_enable_o | magic_wake_pending |
                            magic_event);
        end
    end

endmodule // wake_up_control

`default_nettype wire

// ===== verilog/wake_map.vh
// Register map, field positions and reset values of the wake-up control.
`ifndef WAKE_MAP_VH
`define WAKE_MAP_VH

`define WAKE_CONTROL_ADDR        16'h5800
`define WAKE_FILTER_ENABLES_ADDR 16'h5808
`define WAKE_STATUS_ADDR         16'h5810
`define WAKE_ADDR_WIDTH          16

`define APM_WAKE_ENABLE_BIT      0
`define PME_ENABLE_BIT           1
`define PME_STATUS_BIT           2
`define ASSERT_WAKE_ON_MAGIC_BIT 3
`define LINK_CHANGE_WAKE_EN_BIT  4
`define LINK_CHANGE_OVERRIDE_BIT 5
`define PHY_WAKE_CAPABLE_BIT     8

`define LINK_CHANGE_FILTER_BIT   0
`define MAGIC_PACKET_FILTER_BIT  1
`define PREDEFINED_FILTER_LSB    0
`define PREDEFINED_FILTER_MSB    7
`define IGNORE_MNG_BIT           15
`define FLEX_FILTER_LSB          16
`define FLEX_FILTER_MSB          23

`define WAKE_CONTROL_RESET       32'h0000_0008
`define WAKE_CONTROL_RW_MASK     32'h0000_013b
`define WAKE_FILTER_RESET        32'h0000_0000
`define WAKE_FILTER_RW_MASK      32'h00ff_80ff
`define WAKE_STATUS_MASK         32'h00ff_00ff

`define NVM_APM_WORD_APM_WAKE_ENABLE_BIT    0
`define NVM_PHY_WORD_WAKE_BIT    8

`endif

// ===== verilog/pin_sync.v
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter       WIDTH     = 1,
    parameter [0:0] RESET_VAL = 1'b0
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // Only the second stage is visible outside.
    always @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= {WIDTH{RESET_VAL}};
            stage2 <= {WIDTH{RESET_VAL}};
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;

endmodule // pin_sync

`default_nettype wire

// ===== dv/rx_peer.sv
// Receive-path model that reports packet matches and link changes.
`timescale 1ns/100ps
`default_nettype none
module rx_peer (
    input  wire logic       clk_i,
    output var  logic       packet_done_o,
    output var  logic [7:0] predefined_match_o,
    output var  logic [7:0] flex_match_o,
    output var  logic       manageability_pass_o,
    output var  logic       link_change_o
);
    initial begin
        packet_done_o = 0;
        predefined_match_o = 8'h00;
        flex_match_o = 8'h00;
        manageability_pass_o = 0;
        link_change_o = 0;
    end
    // Match lines carry the inverse of the last value outside a report.
    task automatic send(input logic [7:0] p, f, input logic m, l);
        @(posedge clk_i);
        packet_done_o <= |{p, f};
        predefined_match_o <= p;
        flex_match_o <= f;
        manageability_pass_o <= m;
        link_change_o <= l;
        @(posedge clk_i);
        packet_done_o <= 0;
        link_change_o <= 0;
        predefined_match_o <= ~p;
        flex_match_o <= ~f;
        manageability_pass_o <= ~m;
        @(posedge clk_i);
    endtask
endmodule // rx_peer
`default_nettype wire

// ===== dv/wake_up_control_sva.sv
// Port assertions for the wake-up control block.
`timescale 1ns/100ps
`default_nettype none
module wake_up_control_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [15:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        power_good_i,
    input wire logic        packet_done_i,
    input wire logic        link_change_i,
    input wire logic        pme_status_o,
    input wire logic        pme_enable_o,
    input wire logic        host_wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = ack_o && !we_i;
    wire ctl = rd && adr_i == 16'h5800;
    a_ack_answer: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
        !pme_status_o && !host_wake_o && !pme_enable_o && !ack_o)
        else $error("outputs active after reset");
    a_wake_status: assert property (host_wake_o |-> pme_status_o)
        else $error("host wake without status");
    a_ctl_reserved: assert property (ctl |->
        (dat_o & 32'hffff_fec0) == 0)
        else $error("control reserved bits set");
    a_ctl_mirror: assert property (ctl |->
        dat_o[2:1] == {$past(pme_status_o), $past(pme_enable_o)})
        else $error("control bits differ from outputs");
    a_flt_reserved: assert property (rd && adr_i == 16'h5808 |->
        (dat_o & 32'hff00_7f00) == 0)
        else $error("filter reserved bits set");
    a_unmapped_zero: assert property (rd && adr_i != 16'h5800 &&
        adr_i != 16'h5808 && adr_i != 16'h5810 |-> dat_o == 0)
        else $error("unmapped read not zero");
    a_pgood_clear: assert property ((!power_good_i)[*4] ##0
        (!packet_done_i && !link_change_i) |=> !pme_status_o)
        else $error("status kept without power good");
endmodule // wake_up_control_sva
bind wake_up_control wake_up_control_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .power_good_i(power_good_i),
    .packet_done_i(packet_done_i), .link_change_i(link_change_i),
    .pme_status_o(pme_status_o), .pme_enable_o(pme_enable_o),
    .host_wake_o(host_wake_o));
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the wake-up control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [15:0] adr_i = 0, nvm_apm = 0, nvm_phy = 0;
    logic [31:0] dat_i = 0, rd;
    logic        nvm_load = 0, cfg_wr = 0, aux = 1, pgood = 1, prst_n = 1;
    logic        cfg_en = 0, cfg_clr = 0;
    wire  [31:0] dat_o;
    wire  [7:0]  pm, fm;
    wire         ack_o, pme_s, pme_e, hwake, pd, mng, lc;
    wire  [31:0] wake = {29'h0, pme_e, hwake, pme_s};
    int          errors = 0, checks_done = 0;
    localparam logic [79:0] rows [6] = '{
        {16'h5800, 32'hffff_ffff, 32'h0000_013b},
        {16'h5800, 32'h0000_0000, 32'h0000_0000},
        {16'h5808, 32'hffff_ffff, 32'h00ff_80ff},
        {16'h5808, 32'h0030_0000, 32'h0030_0000},
        {16'h5810, 32'hffff_ffff, 32'h0000_0000},
        {16'h5804, 32'hffff_ffff, 32'h0000_0000}};
    wake_up_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .nvm_load_i(nvm_load),
        .nvm_apm_word_i(nvm_apm), .nvm_phy_word_i(nvm_phy),
        .packet_done_i(pd), .predefined_match_i(pm), .flex_match_i(fm),
        .manageability_pass_i(mng), .link_change_i(lc),
        .cfg_pme_enable_write_i(cfg_wr), .cfg_pme_enable_i(cfg_en),
        .cfg_pme_status_clear_i(cfg_clr), .auxiliary_power_present_i(aux),
        .power_good_i(pgood), .pci_reset_n_i(prst_n),
        .pme_status_o(pme_s), .pme_enable_o(pme_e), .host_wake_o(hwake));
    rx_peer u_peer (.clk_i(clk_i), .packet_done_o(pd),
        .predefined_match_o(pm), .flex_match_o(fm),
        .manageability_pass_o(mng), .link_change_o(lc));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        wb(0, a, 0);
        check(rd, exp);
    endtask
    task automatic wk(input logic [31:0] exp);
        repeat (6) @(posedge clk_i);
        check(wake, exp);
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #20us;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wk(0);
        rdchk(16'h5800, 32'h8);
        rdchk(16'h5808, 0);
        foreach (rows[i]) begin
            wb(1, rows[i][79:64], rows[i][63:32]);
            rdchk(rows[i][79:64], rows[i][31:0]);
        end
        nvm_apm <= 16'h0001;
        nvm_phy <= 16'h0100;
        nvm_load <= 1;
        @(posedge clk_i);
        nvm_load <= 0;
        rdchk(16'h5800, 32'h101);
        wb(1, 16'h5800, 32'h9);
        wb(1, 16'h5808, 32'h2);
        u_peer.send(8'h02, 0, 0, 0);
        wk(3);
        rdchk(16'h5810, 32'h2);
        rdchk(16'h5800, 32'hd);
        wb(1, 16'h5800, 32'h9);
        wk(3);
        wb(1, 16'h5800, 32'hd);
        wk(0);
        rdchk(16'h5810, 32'h2);
        wb(1, 16'h5810, 32'h2);
        rdchk(16'h5810, 0);
        wb(1, 16'h5808, 32'h8002);
        rdchk(16'h5808, 32'h8002);
        u_peer.send(8'h02, 0, 1, 0);
        wk(0);
        wb(1, 16'h5808, 32'h0010_001c);
        wb(1, 16'h5800, 32'h2);
        u_peer.send(8'h0c, 8'h11, 0, 0);
        wk(7);
        rdchk(16'h5810, 32'h0010_000c);
        cfg_wr <= 1;
        @(posedge clk_i);
        cfg_wr <= 0;
        rdchk(16'h5800, 32'h4);
        prst_n <= 0;
        wk(1);
        prst_n <= 1;
        wk(1);
        aux <= 0;
        prst_n <= 0;
        wk(1);
        prst_n <= 1;
        wk(0);
        rdchk(16'h5810, 0);
        wb(1, 16'h5808, 32'h1);
        wb(1, 16'h5800, 32'h0);
        u_peer.send(0, 0, 0, 1);
        wk(1);
        rdchk(16'h5810, 32'h1);
        pgood <= 0;
        wk(0);
        pgood <= 1;
        rdchk(16'h5810, 0);
        wb(1, 16'h5800, 32'h20);
        u_peer.send(0, 0, 0, 1);
        wk(0);
        wb(1, 16'h5800, 32'h31);
        u_peer.send(0, 0, 0, 1);
        wk(1);
        cfg_clr <= 1;
        @(posedge clk_i);
        cfg_clr <= 0;
        wk(0);
        cfg_en <= 1;
        cfg_wr <= 1;
        @(posedge clk_i);
        cfg_wr <= 0;
        rdchk(16'h5800, 32'h33);
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wk(0);
        rdchk(16'h5800, 32'h8);
        rdchk(16'h5808, 0);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
